// file: src/ltd_csum.v
// 16-bit ones-complement accumulator fed one byte at a time
// assumes the caller tells it whether the byte is the high half of a word
`timescale 1ns/10ps
module ltd_csum (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// byte feed
	input  wire        clear,
	input  wire        byte_valid,
	input  wire        byte_high,
	input  wire [7:0]  byte_data,
	// result
	output reg  [15:0] sum
);

	wire [15:0] term;
	wire [16:0] raw;

	assign term = byte_high ? {byte_data, 8'h00} : {8'h00, byte_data};
	assign raw  = {1'b0, sum} + {1'b0, term};

	// end-around carry keeps the sum in ones-complement form
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sum <= 16'h0000;
		else if (clear)
			sum <= 16'h0000;
		else if (byte_valid)
			sum <= raw[15:0] + {15'h0000, raw[16]};
	end

endmodule // ltd_csum

// file: src/ltd_map.vh
// register map, descriptor field layout and limits of the legacy transmit engine
// assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef LTD_MAP_VH
`define LTD_MAP_VH

// register byte offsets
`define LTD_REG_CTRL        8'h00
`define LTD_REG_BASE_LO     8'h04
`define LTD_REG_BASE_HI     8'h08
`define LTD_REG_RING_LEN    8'h0c
`define LTD_REG_HEAD        8'h10
`define LTD_REG_TAIL        8'h14
`define LTD_REG_PKT_LIMIT   8'h18
`define LTD_REG_STATUS      8'h1c
`define LTD_REG_PKT_COUNT   8'h20
`define LTD_REG_DROP_COUNT  8'h24

// control register fields
`define LTD_CTRL_ENABLE     0
`define LTD_CTRL_VLAN       6

// reset values
`define LTD_RING_LEN_RST    16'h0008
`define LTD_PKT_LIMIT_RST   16'h2336

// descriptor layout: word 2 = length/insert offset/command, word 3 = status/start/special
`define LTD_DESC_BYTES      64'h0000000000000010
`define LTD_WB_OFFSET       64'h000000000000000c
`define LTD_CMD_LAST        0
`define LTD_CMD_CSUM        2
`define LTD_CMD_REPORT      3
`define LTD_CMD_EXT         5
`define LTD_CMD_VLAN        6
`define LTD_STA_DONE        0

// transfer sizes on the host memory port
`define LTD_MEM_WORD        1'b0
`define LTD_MEM_BYTE        1'b1

`endif

// file: src/ltd_tx_engine.v
// legacy transmit descriptor engine: ring walk, buffer fetch, checksum insert, write-back
// assumes AHB-Lite register access, a host memory port on hclk, and a byte stream sink
//
// Operation
// - zero buffer address fetches no data
// - report status writes done flag, null too
// - fetch exactly buffer length bytes per descriptor
// - packet size limited by programmed buffer limit
// - zero length descriptor is null, no data
// - checksum written at insert offset from start
// - checksum accumulation begins at start offset
// - both offsets count bytes, not words
// - no UDP checksum for legacy descriptors
// - insert offset eight bits, at most 255
// - end flag marks packet's last descriptor
// - insert flag inserts checksum over packet remainder
// - insert flag ignored without end flag
// - out-of-range offsets skip the checksum insertion; an insert offset at the last byte gets only the checksum high byte
// - extended flag clear means legacy format
// - write-back only when report status set
// - VLAN insert ignored unless VLAN mode enabled
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "ltd_map.vh"
module ltd_tx_engine #(
	parameter DEPTH = 16384,
	parameter AW    = 14
) (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// host memory port
	output reg         mem_req,
	output reg         mem_write,
	output reg         mem_size,
	output reg  [63:0] mem_addr,
	output reg  [31:0] mem_wdata,
	input  wire [31:0] mem_rdata,
	input  wire        mem_ack,
	// transmit byte stream
	output reg         tx_valid,
	output reg  [7:0]  tx_data,
	output reg         tx_last,
	input  wire        tx_ready,
	output reg         tx_vlan_insert,
	output reg  [15:0] tx_vlan_tag
);

	localparam [3:0] S_IDLE  = 4'h0;
	localparam [3:0] S_DESC  = 4'h1;
	localparam [3:0] S_DEC   = 4'h2;
	localparam [3:0] S_DATA  = 4'h3;
	localparam [3:0] S_WB    = 4'h4;
	localparam [3:0] S_NEXT  = 4'h5;
	localparam [3:0] S_CS_HI = 4'h6;
	localparam [3:0] S_CS_LO = 4'h7;
	localparam [3:0] S_SEND  = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// registers and bus slave

	reg         ctrl_enable;
	reg         ctrl_vlan_mode;
	reg  [31:0] base_lo;
	reg  [31:0] base_hi;
	reg  [15:0] ring_len;
	reg  [15:0] head;
	reg  [15:0] tail;
	reg  [15:0] pkt_limit;
	reg  [15:0] pkt_count;
	reg  [15:0] drop_count;
	reg         ext_seen;
	reg         wr_pend;
	reg  [7:0]  wr_addr;
	reg  [3:0]  state;

	wire        addr_take;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_take = hsel && hready && htrans[1];

	function [15:0] ring_inc;
		input [15:0] ptr;
		input [15:0] len;
		begin
			ring_inc = (ptr + 16'h0001 >= len) ? 16'h0000 : ptr + 16'h0001;
		end
	endfunction

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata  <= 32'h00000000;
		end else begin
			wr_pend <= addr_take && hwrite;
			wr_addr <= haddr[7:0];
			// read data captured in the address phase so it stands from a flop
			if (addr_take && !hwrite) begin
				case (haddr[7:0])
				`LTD_REG_CTRL:       hrdata <= {25'h0, ctrl_vlan_mode, 5'h00, ctrl_enable};
				`LTD_REG_BASE_LO:    hrdata <= base_lo;
				`LTD_REG_BASE_HI:    hrdata <= base_hi;
				`LTD_REG_RING_LEN:   hrdata <= {16'h0000, ring_len};
				`LTD_REG_HEAD:       hrdata <= {16'h0000, head};
				`LTD_REG_TAIL:       hrdata <= {16'h0000, tail};
				`LTD_REG_PKT_LIMIT:  hrdata <= {16'h0000, pkt_limit};
				`LTD_REG_STATUS:     hrdata <= {26'h0000000, ext_seen, (state != S_IDLE), state};
				`LTD_REG_PKT_COUNT:  hrdata <= {16'h0000, pkt_count};
				`LTD_REG_DROP_COUNT: hrdata <= {16'h0000, drop_count};
				default:             hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_enable <= 1'b0;
			ctrl_vlan_mode <= 1'b0;
			base_lo     <= 32'h00000000;
			base_hi     <= 32'h00000000;
			ring_len    <= `LTD_RING_LEN_RST;
			tail        <= 16'h0000;
			pkt_limit   <= `LTD_PKT_LIMIT_RST;
		end else if (wr_pend) begin
			case (wr_addr)
			`LTD_REG_CTRL: begin
				ctrl_enable <= hwdata[`LTD_CTRL_ENABLE];
				ctrl_vlan_mode <= hwdata[`LTD_CTRL_VLAN];
			end
			`LTD_REG_BASE_LO:   base_lo   <= {hwdata[31:4], 4'h0};
			`LTD_REG_BASE_HI:   base_hi   <= hwdata;
			`LTD_REG_RING_LEN:  ring_len  <= hwdata[15:0];
			`LTD_REG_TAIL:      tail      <= hwdata[15:0];
			`LTD_REG_PKT_LIMIT: pkt_limit <= hwdata[15:0];
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// descriptor walk and packet assembly

	reg  [7:0]  pkt_buf [0:DEPTH-1];
	reg  [31:0] dw0;
	reg  [31:0] dw1;
	reg  [31:0] dw2;
	reg  [31:0] dw3;
	reg  [1:0]  word_idx;
	reg  [15:0] bytes_left;
	reg  [63:0] data_addr;
	reg  [15:0] pkt_len;
	reg  [15:0] rd_ptr;
	reg  [7:0]  csum_start;
	reg  [7:0]  csum_ins;
	reg         first_desc;
	reg         oversize;
	reg         do_csum;

	wire [63:0] desc_addr;
	wire [15:0] dlen;
	wire [7:0]  dcmd;
	wire        store;
	wire        in_csum;
	wire        cs_clear;
	wire [15:0] csum;
	wire [15:0] eff_limit;

	assign desc_addr = {base_hi, base_lo} + ({48'h000000000000, head} << 4);
	assign dlen      = dw2[15:0];
	assign dcmd      = dw2[31:24];
	// store only while under the programmed size limit
	assign eff_limit = (pkt_limit > DEPTH[15:0]) ? DEPTH[15:0] : pkt_limit;
	assign store     = (state == S_DATA) && mem_ack && (pkt_len < eff_limit);
	// the start offset is a byte position; parity is taken relative to it
	assign in_csum   = store && (pkt_len >= {8'h00, csum_start});
	// cleared only between packets: the sum runs on across all descriptors of one packet
	assign cs_clear  = (state == S_IDLE) && first_desc;

	ltd_csum u_csum (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.clear      (cs_clear),
		.byte_valid (in_csum),
		.byte_high  (~(pkt_len[0] ^ csum_start[0])),
		.byte_data  (mem_rdata[7:0]),
		.sum        (csum)
	);

	always @(posedge hclk) begin
		if (store)
			pkt_buf[pkt_len[AW-1:0]] <= mem_rdata[7:0];
		else if ((state == S_CS_HI) && do_csum)
			pkt_buf[{{(AW-8){1'b0}}, csum_ins}] <= ~csum[15:8];
		else if (state == S_CS_LO)
			pkt_buf[{{(AW-8){1'b0}}, csum_ins} + 1'b1] <= ~csum[7:0];
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state          <= S_IDLE;
			head           <= 16'h0000;
			mem_req        <= 1'b0;
			mem_write      <= 1'b0;
			mem_size       <= `LTD_MEM_WORD;
			mem_addr       <= 64'h0000000000000000;
			mem_wdata      <= 32'h00000000;
			dw0            <= 32'h00000000;
			dw1            <= 32'h00000000;
			dw2            <= 32'h00000000;
			dw3            <= 32'h00000000;
			word_idx       <= 2'h0;
			bytes_left     <= 16'h0000;
			data_addr      <= 64'h0000000000000000;
			pkt_len        <= 16'h0000;
			rd_ptr         <= 16'h0000;
			csum_start     <= 8'h00;
			csum_ins       <= 8'h00;
			first_desc     <= 1'b1;
			oversize       <= 1'b0;
			do_csum        <= 1'b0;
			ext_seen       <= 1'b0;
			pkt_count      <= 16'h0000;
			drop_count     <= 16'h0000;
			tx_valid       <= 1'b0;
			tx_data        <= 8'h00;
			tx_last        <= 1'b0;
			tx_vlan_insert <= 1'b0;
			tx_vlan_tag    <= 16'h0000;
		end else begin
			case (state)
			S_IDLE: begin
				if (ctrl_enable && (head != tail)) begin
					state     <= S_DESC;
					word_idx  <= 2'h0;
					mem_req   <= 1'b1;
					mem_write <= 1'b0;
					mem_size  <= `LTD_MEM_WORD;
					mem_addr  <= desc_addr;
				end
			end
			S_DESC: begin
				if (mem_ack) begin
					case (word_idx)
					2'h0:    dw0 <= mem_rdata;
					2'h1:    dw1 <= mem_rdata;
					2'h2:    dw2 <= mem_rdata;
					default: dw3 <= mem_rdata;
					endcase
					word_idx <= word_idx + 2'h1;
					mem_addr <= mem_addr + 64'h0000000000000004;
					if (word_idx == 2'h3) begin
						mem_req <= 1'b0;
						state   <= S_DEC;
					end
				end
			end
			S_DEC: begin
				if (dcmd[`LTD_CMD_EXT]) begin
					// extended formats are not handled here: flagged and stepped over
					ext_seen <= 1'b1;
					state    <= S_NEXT;
				end else begin
					if (first_desc)
						csum_start <= dw3[15:8];
					first_desc <= 1'b0;
					bytes_left <= dlen;
					data_addr  <= {dw1, dw0};
					if (({dw1, dw0} == 64'h0000000000000000) || (dlen == 16'h0000)) begin
						state <= S_WB;
					end else begin
						state    <= S_DATA;
						mem_req  <= 1'b1;
						mem_size <= `LTD_MEM_BYTE;
						mem_addr <= {dw1, dw0};
					end
				end
			end
			S_DATA: begin
				if (mem_ack) begin
					if (pkt_len >= eff_limit)
						oversize <= 1'b1;
					else
						pkt_len <= pkt_len + 16'h0001;
					bytes_left <= bytes_left - 16'h0001;
					mem_addr   <= mem_addr + 64'h0000000000000001;
					if (bytes_left == 16'h0001) begin
						mem_req <= 1'b0;
						state   <= S_WB;
					end
				end
			end
			S_WB: begin
				if (!dcmd[`LTD_CMD_REPORT]) begin
					state <= S_NEXT;
				end else if (!mem_req) begin
					mem_req   <= 1'b1;
					mem_write <= 1'b1;
					mem_size  <= `LTD_MEM_WORD;
					mem_addr  <= desc_addr + `LTD_WB_OFFSET;
					mem_wdata <= dw3 | (32'h00000001 << `LTD_STA_DONE);
				end else if (mem_ack) begin
					mem_req   <= 1'b0;
					mem_write <= 1'b0;
					state     <= S_NEXT;
				end
			end
			S_NEXT: begin
				head <= ring_inc(head, ring_len);
				if (!dcmd[`LTD_CMD_LAST] || dcmd[`LTD_CMD_EXT]) begin
					state <= S_IDLE;
				end else begin
					first_desc <= 1'b1;
					// insert flag and offset only count on the last descriptor
					csum_ins <= dw2[23:16];
					do_csum <= dcmd[`LTD_CMD_CSUM] && ({8'h00, csum_start} < pkt_len)
						&& ({8'h00, dw2[23:16]} <= pkt_len - 16'h0001);
					tx_vlan_insert <= dcmd[`LTD_CMD_VLAN] && ctrl_vlan_mode;
					tx_vlan_tag    <= dw3[31:16];
					if (oversize) begin
						drop_count <= drop_count + 16'h0001;
						pkt_len    <= 16'h0000;
						oversize   <= 1'b0;
						state      <= S_IDLE;
					end else if (pkt_len == 16'h0000) begin
						state <= S_IDLE;
					end else begin
						state <= S_CS_HI;
					end
				end
			end
			S_CS_HI: begin
				// insertion only after the whole packet sits in the buffer; TCP only
				if (do_csum && ({8'h00, csum_ins} + 16'h0001 < pkt_len))
					state <= S_CS_LO;
				else
					state <= S_SEND;
				if (!do_csum)
					state <= S_SEND;
				if (state == S_CS_HI && !do_csum)
					rd_ptr <= 16'h0000;
			end
			S_CS_LO: begin
				state <= S_SEND;
			end
			S_SEND: begin
				if (!tx_valid && rd_ptr == 16'h0000) begin
					tx_valid <= 1'b1;
					tx_data  <= pkt_buf[{AW{1'b0}}];
					tx_last  <= (pkt_len == 16'h0001);
					rd_ptr   <= 16'h0001;
				end else if (tx_valid && tx_ready) begin
					if (tx_last) begin
						tx_valid       <= 1'b0;
						tx_last        <= 1'b0;
						tx_vlan_insert <= 1'b0;
						rd_ptr         <= 16'h0000;
						pkt_len        <= 16'h0000;
						pkt_count      <= pkt_count + 16'h0001;
						state          <= S_IDLE;
					end else begin
						tx_data <= pkt_buf[rd_ptr[AW-1:0]];
						tx_last <= (rd_ptr == pkt_len - 16'h0001);
						rd_ptr  <= rd_ptr + 16'h0001;
					end
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end

endmodule // ltd_tx_engine

// file: testbench/ltd_assertions.sv
// port assertions for the legacy transmit engine
// assumes a bind onto ltd_tx_engine with one clock domain
`timescale 1ns/10ps
module ltd_assertions (
	// clock and reset
	input wire        hclk,
	input wire        hresetn,
	// watched ports
	input wire        hreadyout,
	input wire        hresp,
	input wire        mem_req,
	input wire        mem_write,
	input wire        mem_size,
	input wire [63:0] mem_addr,
	input wire [31:0] mem_wdata,
	input wire        mem_ack,
	input wire        tx_valid,
	input wire [7:0]  tx_data,
	input wire        tx_last,
	input wire        tx_ready
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////////////
	a_bus_ready: assert property (hreadyout && !hresp) else $error("bus not ready or error");
	a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_write) && $stable(mem_size)) else $error("memory request dropped");
	a_byte_step: assert property ((mem_req && mem_ack && mem_size && !mem_write) ##1
		(mem_req && mem_size && !mem_write) |-> mem_addr == $past(mem_addr) + 64'h1)
		else $error("byte fetch address skipped");
	a_wb_done: assert property (mem_req && mem_write |-> !mem_size && mem_wdata[0]
		&& mem_addr[3:0] == 4'hc) else $error("bad status write-back");
	a_send_after: assert property (mem_req && !mem_write |-> !tx_valid)
		else $error("sending while fetching");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
		&& $stable(tx_last)) else $error("stream byte not held");
	a_last_gap: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
		else $error("byte after packet end");
	a_req_ack: assert property ($rose(mem_req) |-> !mem_ack) else $error("ack with request");
endmodule // ltd_assertions

bind ltd_tx_engine ltd_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_write(mem_write),
	.mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

// file: testbench/ltd_host_mem.sv
// host memory holding descriptors and buffers
// assumes one request at a time on hclk; slow adds three wait cycles
`timescale 1ns/10ps
module ltd_host_mem (
	// clock and pace
	input wire        hclk,
	input wire        slow,
	// memory port
	input wire        mem_req,
	input wire        mem_write,
	input wire        mem_size,
	input wire [63:0] mem_addr,
	input wire [31:0] mem_wdata,
	output reg [31:0] mem_rdata,
	output reg        mem_ack
);
	reg [7:0]  m [0:4095];
	reg [1:0]  wait_cnt;
	wire [11:0] a = mem_addr[11:0];
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		wait_cnt = 2'h0;
	end
	always @(posedge hclk) begin
		mem_ack <= 1'b0;
		// idle data flips every cycle, so a sample one cycle stale cannot pass
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			wait_cnt <= wait_cnt + 2'h1;
			if (!slow || wait_cnt == 2'h3) begin
				mem_ack <= 1'b1;
				wait_cnt <= 2'h0;
				if (mem_write) begin
					{m[a + 12'h3], m[a + 12'h2], m[a + 12'h1], m[a]} <= mem_wdata;
				end else if (mem_size) begin
					mem_rdata <= {24'h0, m[a]};
				end else begin
					mem_rdata <= {m[a + 12'h3], m[a + 12'h2], m[a + 12'h1], m[a]};
				end
			end
		end
	end
endmodule // ltd_host_mem

// file: testbench/tb.sv
// self-checking bench for the legacy transmit engine
// assumes the host memory model and the bound port checker
`timescale 1ns/10ps
`include "ltd_map.vh"
module tb;
	reg         hclk, hresetn, hsel, hwrite, tx_ready, slow;
	reg  [1:0]  htrans;
	reg  [2:0]  hsize;
	reg  [31:0] haddr, hwdata, rd;
	wire        hreadyout, hresp, mem_req, mem_write, mem_size, mem_ack;
	wire        tx_valid, tx_last, tx_vlan_insert;
	wire [31:0] hrdata, mem_wdata, mem_rdata;
	wire [63:0] mem_addr;
	wire [7:0]  tx_data;
	wire [15:0] tx_vlan_tag;
	integer     num_errors = 0, samples_checked = 0, nbytes = 0, i;
	reg  [7:0]  rxq[$], expq[$];
	reg  [2:0]  tail = 3'h0;
	reg         vlan_seen = 1'b0;
	reg  [15:0] tag_seen = 16'h0000;
	ltd_tx_engine #(.DEPTH(1024), .AW(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mem_req(mem_req), .mem_write(mem_write), .mem_size(mem_size), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.tx_vlan_insert(tx_vlan_insert), .tx_vlan_tag(tx_vlan_tag));
	ltd_host_mem u_mem (.hclk(hclk), .slow(slow), .mem_req(mem_req), .mem_write(mem_write),
		.mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// sink stalls every other cycle
	always @(posedge hclk) begin
		if (tx_valid === 1'b1 && tx_ready) rxq.push_back(tx_data);
		// vlan outputs stand for the whole packet; taken with its last byte
		if (tx_valid === 1'b1 && tx_ready && tx_last) begin
			vlan_seen = tx_vlan_insert;
			tag_seen = tx_vlan_tag;
		end
		if (mem_req && mem_ack && mem_size && !mem_write) nbytes = nbytes + 1;
		tx_ready <= ~tx_ready;
	end
	////////////////////////////////////////////////////////////////////////////////
	task check(input string what, input [31:0] seen, input [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task ahb(input [31:0] a, input w, input [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hsize <= 3'b010;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task put_desc(input [31:0] a, input [15:0] len, input [7:0] ins_off, cmd, start_off);
		{u_mem.m[tail*16+3], u_mem.m[tail*16+2], u_mem.m[tail*16+1], u_mem.m[tail*16]} = a;
		for (i = 4; i < 16; i = i + 1) u_mem.m[tail*16+i] = 8'h00;
		{u_mem.m[tail*16+11], u_mem.m[tail*16+10], u_mem.m[tail*16+9], u_mem.m[tail*16+8]}
			= {cmd, ins_off, len};
		u_mem.m[tail*16+13] = start_off;
		// fixed vlan tag in the special field
		u_mem.m[tail*16+14] = 8'h5a;
		u_mem.m[tail*16+15] = 8'ha5;
		tail = tail + 3'h1;
	endtask
	task fill(input [11:0] a, input integer n, input [7:0] s);
		for (i = 0; i < n; i = i + 1) begin
			u_mem.m[a+i] = s + i[7:0];
			expq.push_back(s + i[7:0]);
		end
	endtask
	// hand descriptors over and wait for the head to catch up and bytes to drain
	task run(input integer nexp);
		integer n;
		rxq.delete();
		ahb(`LTD_REG_TAIL, 1'b1, {29'h0, tail});
		rd = 32'hffffffff;
		for (n = 0; n < 500 && rd !== {29'h0, tail}; n = n + 1) ahb(`LTD_REG_HEAD, 1'b0, 0);
		for (n = 0; n < 4000 && rxq.size() < nexp; n = n + 1) @(posedge hclk);
		repeat (40) @(posedge hclk);
		check("sent bytes", rxq.size(), nexp);
		for (i = 0; i < nexp && i < rxq.size(); i = i + 1) check("byte", rxq[i], expq[i]);
		expq.delete();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		ahb(`LTD_REG_RING_LEN, 1'b0, 0);
		check("ring length", rd, 32'h00000008);
		ahb(`LTD_REG_PKT_LIMIT, 1'b0, 0);
		check("packet limit", rd, 32'h00002336);
		ahb(32'h00000030, 1'b0, 0);
		check("unmapped", rd, 32'h00000000);
		ahb(`LTD_REG_HEAD, 1'b1, 32'h00000005);
		ahb(`LTD_REG_HEAD, 1'b0, 0);
		check("head read-only", rd, 32'h00000000);
	endtask
	task t_packet;
		reg [16:0] s;
		integer n;
		n = nbytes;
		fill(12'h400, 6, 8'h10);
		fill(12'h500, 4, 8'h80);
		// insert flag on a middle descriptor must be disregarded
		put_desc(32'h400, 16'h6, 8'h00, 8'h04, 8'h02);
		put_desc(32'h500, 16'h4, 8'h02, 8'h0d, 8'h00);
		s = 17'h0;
		for (i = 2; i < 10; i = i + 1) begin
			s = s + (i[0] ? {9'h0, expq[i]} : {1'b0, expq[i], 8'h00});
			s = {1'b0, s[15:0]} + {16'h0, s[16]};
		end
		expq[2] = ~s[15:8];
		expq[3] = ~s[7:0];
		run(10);
		check("bytes fetched", nbytes - n, 10);
		check("done flag", {31'h0, u_mem.m[16+12][0]}, 1);
		check("no done flag", {31'h0, u_mem.m[12][0]}, 0);
	endtask
	task t_null;
		integer n;
		n = nbytes;
		put_desc(32'h0, 16'h4, 8'h00, 8'h09, 8'h00);
		put_desc(32'h600, 16'h0, 8'h00, 8'h09, 8'h00);
		// extended descriptor: stepped over, no fetch and no status write
		put_desc(32'h600, 16'h4, 8'h00, 8'h29, 8'h00);
		run(0);
		check("null fetch", nbytes - n, 0);
		check("null done a", {31'h0, u_mem.m[32+12][0]}, 1);
		check("null done b", {31'h0, u_mem.m[48+12][0]}, 1);
		check("extended done", {31'h0, u_mem.m[64+12][0]}, 0);
		ahb(`LTD_REG_STATUS, 1'b0, 0);
		check("extended seen", rd & 32'h00000020, 32'h00000020);
	endtask
	task t_range;
		slow <= 1'b1;
		fill(12'h700, 4, 8'h40);
		// start offset at the length: no insertion, byte 1 left alone
		put_desc(32'h700, 16'h4, 8'h01, 8'h45, 8'h04);
		run(4);
		check("vlan ignored", {31'h0, vlan_seen}, 0);
		slow <= 1'b0;
		ahb(`LTD_REG_CTRL, 1'b1, 32'h00000041);
		fill(12'h780, 3, 8'h60);
		// insert offset past the last byte: no insertion
		put_desc(32'h780, 16'h3, 8'h03, 8'h45, 8'h00);
		run(3);
		check("vlan insert", {31'h0, vlan_seen}, 1);
		check("vlan tag", {16'h0, tag_seen}, 32'h0000a55a);
	endtask
	task t_limit;
		integer n;
		ahb(`LTD_REG_PKT_LIMIT, 1'b1, 32'h00000004);
		n = nbytes;
		fill(12'h800, 5, 8'h20);
		// five bytes against a limit of four: fetched in full, never sent
		put_desc(32'h800, 16'h5, 8'h00, 8'h01, 8'h00);
		run(0);
		check("oversize fetch", nbytes - n, 5);
		ahb(`LTD_REG_DROP_COUNT, 1'b0, 0);
		check("drop count", rd, 32'h00000001);
		ahb(`LTD_REG_PKT_COUNT, 1'b0, 0);
		check("packet count", rd, 32'h00000003);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors = num_errors + 1;
		close_out;
	end
	initial begin
		{hresetn, hsel, hwrite, tx_ready, slow, htrans} = 7'h00;
		hsize = 3'b010;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		ahb(`LTD_REG_CTRL, 1'b1, 32'h00000001);
		t_packet;
		t_null;
		t_range;
		t_limit;
		close_out;
	end
endmodule // tb
